/* rtl/wwdg_pkg.sv */
// constants, types and helpers for the windowed watchdog
// assumes a 20 MHz bus clock and a slow counter clock near 1 kHz
package wwdg_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] WWDG_OFS_CTRL    = 8'h00;
	localparam logic [7:0] WWDG_OFS_CONFIG  = 8'h04;
	localparam logic [7:0] WWDG_OFS_WARN    = 8'h08;
	localparam logic [7:0] WWDG_OFS_IEN_CLR = 8'h0c;
	localparam logic [7:0] WWDG_OFS_IEN_SET = 8'h10;
	localparam logic [7:0] WWDG_OFS_IFLAG   = 8'h14;
	localparam logic [7:0] WWDG_OFS_STATUS  = 8'h18;
	localparam logic [7:0] WWDG_OFS_RESTART = 8'h1c;

	// ****************************************
	// field positions
	// ****************************************
	localparam int WWDG_CTRL_ENABLE_BIT  = 1;
	localparam int WWDG_CTRL_WINDOW_BIT  = 2;
	localparam int WWDG_CTRL_PERSIST_BIT = 7;
	localparam int WWDG_CFG_OPEN_LSB     = 0;
	localparam int WWDG_CFG_CLOSED_LSB   = 4;
	localparam int WWDG_WARN_LSB         = 0;
	localparam int WWDG_EW_BIT           = 0;
	localparam int WWDG_STAT_RESET_BIT   = 0;
	localparam int WWDG_STAT_PHASE_LSB   = 1;
	localparam int WWDG_SEL_W            = 4;
	localparam int WWDG_TICK_W           = 15;

	// ****************************************
	// reset values and keys
	// ****************************************
	localparam logic [3:0]  WWDG_OPEN_RST   = 4'hb;
	localparam logic [3:0]  WWDG_CLOSED_RST = 4'hb;
	localparam logic [3:0]  WWDG_WARN_RST   = 4'hb;
	localparam logic [7:0]  WWDG_RESTART_KEY = 8'ha5;

	// ****************************************
	// timing: periods span 8 ms to 16 s of counter clock
	// ****************************************
	localparam int WWDG_MIN_PERIOD_MS = 8;
	localparam int WWDG_MAX_PERIOD_MS = 16000;
	localparam logic [3:0]  WWDG_SEL_MAX    = 4'hb;
	localparam logic [14:0] WWDG_BASE_TICKS = 15'h0008;

	typedef enum logic [1:0] {
		WWDG_IDLE,
		WWDG_CLOSED,
		WWDG_OPEN
	} wwdg_phase_e;

	// selection code to counter-clock ticks, 8 << sel, clamped
	function automatic logic [14:0] wwdg_period_ticks(input logic [3:0] sel);
		logic [3:0] s;
		s = (sel > WWDG_SEL_MAX) ? WWDG_SEL_MAX : sel;
		return WWDG_BASE_TICKS << s;
	endfunction

endpackage

/* rtl/wwdg_top.sv */
// windowed watchdog: apb register slave plus timeout engine
// assumes counter_clock is a slow free clock from outside, sampled here
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/100ps

// How it works
// - window mode restart only by key 0xa5 written during open period
// - key restart during closed period raises system reset
// - closed and open periods each 8 ms to 16 s; total is their sum
// - closed length from closed select field, open length from open select
// - early warning interrupt enable clears at reset
// - writing one to set register bit enables early warning
// - writing one to clear register bit disables early warning
// - window mode early warning fires when closed period expires
// - persistent run bit set to one turns on always-on running
// - always-on counts whatever the ordinary enable bit says
// - persistent run bit ignores software clears; only power-on reset clears
// - persistent run locks timing and warning configuration registers
// - window select stays writable during always-on operation
// - counter counts edges of its own asynchronous clock, synchronised into bus domain
// - bus interface enabled after reset; power manager may disable it
// - counting continues in sleep while the counter clock runs
// - watchdog interrupt drives a wake request
// - watchdog events pulse out without needing wake-up
module wwdg_top
	import wwdg_pkg::*;
(
	input  wire logic        pclk,          // bus clock
	input  wire logic        presetn,       // power-on reset, low
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb enable
	input  wire logic        pwrite,        // apb direction
	input  wire logic [7:0]  paddr,         // apb byte address
	input  wire logic [31:0] pwdata,        // apb write data
	output logic      [31:0] prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb error, unmapped
	input  wire logic        bus_clk_on,    // power manager bus clock gate
	input  wire logic        counter_clock, // slow counter clock
	output logic             irq,           // early warning interrupt
	output logic             wake_req,      // sleep wake request
	output logic             ew_event,      // early warning event pulse
	output logic             sys_reset_req  // system reset request
);

	// ****************************************
	// state
	// ****************************************
	logic                   enable;
	logic                   window_sel;
	logic                   persist;
	logic [WWDG_SEL_W-1:0]  open_period_select;
	logic [WWDG_SEL_W-1:0]  closed_period_select;
	logic [WWDG_SEL_W-1:0]  warning_offset_select;
	logic                   ew_enable;
	logic                   ew_flag;
	logic                   ck_s1;
	logic                   ck_s2;
	logic                   ck_s3;
	logic                   ck_lvl;
	wwdg_phase_e            phase;
	wwdg_phase_e            next_phase;
	logic [WWDG_TICK_W-1:0] cnt;
	logic [WWDG_TICK_W-1:0] next_cnt;
	logic                   ew_hit;
	logic                   bite;

	// ****************************************
	// apb decode
	// ****************************************
	// address match against one register offset
	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	wire logic access   = psel & penable;
	wire logic done     = access & pready;
	wire logic wr       = done & pwrite & bus_clk_on;
	wire logic sel_ctrl = addr_is(paddr, WWDG_OFS_CTRL);
	wire logic sel_cfg  = addr_is(paddr, WWDG_OFS_CONFIG);
	wire logic sel_warn = addr_is(paddr, WWDG_OFS_WARN);
	wire logic sel_iclr = addr_is(paddr, WWDG_OFS_IEN_CLR);
	wire logic sel_iset = addr_is(paddr, WWDG_OFS_IEN_SET);
	wire logic sel_iflg = addr_is(paddr, WWDG_OFS_IFLAG);
	wire logic sel_stat = addr_is(paddr, WWDG_OFS_STATUS);
	wire logic sel_rst  = addr_is(paddr, WWDG_OFS_RESTART);
	wire logic map_hit  = sel_ctrl | sel_cfg | sel_warn | sel_iclr | sel_iset |
	                      sel_iflg | sel_stat | sel_rst;
	wire logic cfg_lock = persist;
	// a wrong key is dropped silently, not treated as a runaway program
	wire logic kick     = wr & sel_rst & (pwdata[7:0] == WWDG_RESTART_KEY);

	// ****************************************
	// read words, built field by field
	// ****************************************
	// unused bits read as zero
	logic [31:0] rd_ctrl;
	logic [31:0] rd_cfg;
	logic [31:0] rd_warn;
	logic [31:0] rd_ien;
	logic [31:0] rd_iflg;
	logic [31:0] rd_stat;

	always_comb begin
		rd_ctrl                        = 32'h00000000;
		rd_ctrl[WWDG_CTRL_ENABLE_BIT]  = enable;
		rd_ctrl[WWDG_CTRL_WINDOW_BIT]  = window_sel;
		rd_ctrl[WWDG_CTRL_PERSIST_BIT] = persist;
	end

	always_comb begin
		rd_cfg                                    = 32'h00000000;
		rd_cfg[WWDG_CFG_OPEN_LSB +: WWDG_SEL_W]   = open_period_select;
		rd_cfg[WWDG_CFG_CLOSED_LSB +: WWDG_SEL_W] = closed_period_select;
	end

	always_comb begin
		rd_warn                              = 32'h00000000;
		rd_warn[WWDG_WARN_LSB +: WWDG_SEL_W] = warning_offset_select;
	end

	// set and clear offsets both read the live enable
	always_comb begin
		rd_ien              = 32'h00000000;
		rd_ien[WWDG_EW_BIT] = ew_enable;
	end

	always_comb begin
		rd_iflg              = 32'h00000000;
		rd_iflg[WWDG_EW_BIT] = ew_flag;
	end

	always_comb begin
		rd_stat                              = 32'h00000000;
		rd_stat[WWDG_STAT_RESET_BIT]         = sys_reset_req;
		rd_stat[WWDG_STAT_PHASE_LSB +: 2]    = phase;
	end

	// gated bus clock: reads return zero but the transfer still ends
	wire logic [31:0] rd_mux  =
		!bus_clk_on        ? 32'h00000000 :
		sel_ctrl           ? rd_ctrl :
		sel_cfg            ? rd_cfg  :
		sel_warn           ? rd_warn :
		(sel_iclr|sel_iset)? rd_ien  :
		sel_iflg           ? rd_iflg :
		sel_stat           ? rd_stat :
		                     32'h00000000;

	// ****************************************
	// apb answer: one wait state, registered outputs
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= access & ~pready;
			pslverr <= access & ~pready & ~map_hit;
			if (access & ~pready) begin
				prdata <= pwrite ? 32'h00000000 : rd_mux;
			end
		end
	end

	// ****************************************
	// control and configuration registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable     <= 1'b0;
			window_sel <= 1'b0;
			persist    <= 1'b0;
		end else if (wr & sel_ctrl) begin
			enable     <= pwdata[WWDG_CTRL_ENABLE_BIT];
			window_sel <= pwdata[WWDG_CTRL_WINDOW_BIT];
			persist    <= persist | pwdata[WWDG_CTRL_PERSIST_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			open_period_select    <= WWDG_OPEN_RST;
			closed_period_select  <= WWDG_CLOSED_RST;
			warning_offset_select <= WWDG_WARN_RST;
		end else begin
			if (wr & sel_cfg & ~cfg_lock) begin
				open_period_select   <= pwdata[WWDG_CFG_OPEN_LSB +: WWDG_SEL_W];
				closed_period_select <= pwdata[WWDG_CFG_CLOSED_LSB +: WWDG_SEL_W];
			end
			if (wr & sel_warn & ~cfg_lock) begin
				warning_offset_select <= pwdata[WWDG_WARN_LSB +: WWDG_SEL_W];
			end
		end
	end

	// ****************************************
	// early warning enable and flag
	// ****************************************
	wire logic ew_set_wr = wr & sel_iset & pwdata[WWDG_EW_BIT];
	wire logic ew_clr_wr = wr & sel_iclr & pwdata[WWDG_EW_BIT];
	wire logic flg_clr   = wr & sel_iflg & pwdata[WWDG_EW_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ew_enable <= 1'b0;
			ew_flag   <= 1'b0;
		end else begin
			if (ew_set_wr) begin
				ew_enable <= 1'b1;
			end else if (ew_clr_wr) begin
				ew_enable <= 1'b0;
			end
			// set wins over a clear in the same cycle
			ew_flag <= ew_hit | (ew_flag & ~flg_clr);
		end
	end

	// ****************************************
	// counter clock sampling
	// ****************************************
	// first flop may go metastable; only the second reads it
	// a level is accepted once second and third agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_s1  <= 1'b0;
			ck_s2  <= 1'b0;
			ck_s3  <= 1'b0;
			ck_lvl <= 1'b0;
		end else begin
			ck_s1 <= counter_clock;
			ck_s2 <= ck_s1;
			ck_s3 <= ck_s2;
			if (ck_s2 == ck_s3) begin
				ck_lvl <= ck_s3;
			end
		end
	end

	// a tick per counter clock rising edge; no ticks if it never runs
	wire logic tick = (ck_s2 == ck_s3) & ck_s3 & ~ck_lvl;

	// ****************************************
	// timeout engine
	// ****************************************
	wire logic                   running      = enable | persist;
	wire logic [WWDG_TICK_W-1:0] closed_ticks = wwdg_period_ticks(closed_period_select);
	wire logic [WWDG_TICK_W-1:0] open_ticks   = wwdg_period_ticks(open_period_select);
	wire logic [WWDG_TICK_W-1:0] warn_ticks   = wwdg_period_ticks(warning_offset_select);
	wire logic [WWDG_TICK_W-1:0] cnt_inc      = cnt + 15'h0001;
	wire wwdg_phase_e            start_phase  = window_sel ? WWDG_CLOSED : WWDG_OPEN;

	// sleep is not an input: counting follows the counter clock only
	// a key in the closed window means a runaway program: bite at once
	// a bite parks the engine until reset clears the request
	always_comb begin
		next_phase = phase;
		next_cnt   = cnt;
		ew_hit     = 1'b0;
		bite       = 1'b0;
		case (phase)
			WWDG_IDLE: begin
				next_cnt = 15'h0000;
				if (running) begin
					next_phase = start_phase;
				end
			end
			WWDG_CLOSED: begin
				if (!window_sel) begin
					next_phase = WWDG_OPEN;
					next_cnt   = 15'h0000;
				end else if (tick) begin
					if (cnt_inc >= closed_ticks) begin
						next_phase = WWDG_OPEN;
						next_cnt   = 15'h0000;
						ew_hit     = 1'b1;
					end else begin
						next_cnt = cnt_inc;
					end
				end
			end
			WWDG_OPEN: begin
				if (tick) begin
					if (cnt_inc >= open_ticks) begin
						bite = 1'b1;
					end else begin
						next_cnt = cnt_inc;
					end
					if (!window_sel && cnt_inc == warn_ticks) begin
						ew_hit = 1'b1;
					end
				end
			end
			default: begin
				next_phase = WWDG_IDLE;
				next_cnt   = 15'h0000;
			end
		endcase
		if (kick && running && phase != WWDG_IDLE) begin
			if (phase == WWDG_CLOSED && window_sel) begin
				bite = 1'b1;
			end else begin
				next_phase = start_phase;
				next_cnt   = 15'h0000;
				ew_hit     = 1'b0;
			end
		end
		if (!running || bite || sys_reset_req) begin
			next_phase = WWDG_IDLE;
			next_cnt   = 15'h0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= WWDG_IDLE;
			cnt   <= 15'h0000;
		end else begin
			phase <= next_phase;
			cnt   <= next_cnt;
		end
	end

	// ****************************************
	// outward signals
	// ****************************************
	// irq and wake share one source; wake needs no bus clock
	// event pulses on every hit, whatever the enable says
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq           <= 1'b0;
			wake_req      <= 1'b0;
			ew_event      <= 1'b0;
			sys_reset_req <= 1'b0;
		end else begin
			irq           <= ew_flag & ew_enable;
			wake_req      <= ew_flag & ew_enable;
			ew_event      <= ew_hit;
			// held until the system reset returns presetn low
			sys_reset_req <= sys_reset_req | bite;
		end
	end

endmodule

/* verif/windowed_watchdog_test.sv */
// bench for the windowed watchdog top
// assumes package and top compiled first
`timescale 1ns/100ps
module windowed_watchdog_test;
	logic        pclk, presetn, psel, penable, pwrite, bus_clk_on, counter_clock, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        pready, pslverr, irq, wake_req, ew_event, sys_reset_req;
	int          n_fail, checked, n, n_ev;
	wwdg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus_clk_on(bus_clk_on),
		.counter_clock(counter_clock), .irq(irq), .wake_req(wake_req),
		.ew_event(ew_event), .sys_reset_req(sys_reset_req));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		counter_clock = 1'b0;
		#137;
		forever #500 counter_clock = ~counter_clock;
	end
	always @(posedge pclk) if (ew_event === 1'b1) n_ev++;
	// ****
	// bus and check tasks
	// ****
	task automatic stop_test;
		if (n_fail == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", s, exp, got);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			if (++i > 20) begin
				n_fail++;
				stop_test();
			end
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input string s, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(s, q, e);
	endtask
	task automatic wait_out(input logic s, input int lim);
		n = 0;
		while ((s ? sys_reset_req : irq) !== 1'b1) begin
			@(posedge pclk);
			if (++n > lim) begin
				n_fail++;
				stop_test();
			end
		end
	endtask
	task automatic do_reset;
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_reset;
		rc("ctrl", 8'h00, 32'h0);
		rc("config", 8'h04, 32'hbb);
		rc("warn", 8'h08, 32'hb);
		rc("ien", 8'h10, 32'h0);
		rc("unmapped", 8'h20, 32'h0);
		chk("slverr", err, 32'h1);
		bus_clk_on <= 1'b0;
		xfer(1'b1, 8'h10, 32'h1);
		bus_clk_on <= 1'b1;
		rc("gated", 8'h10, 32'h0);
	endtask
	task automatic t_window;
		xfer(1'b1, 8'h04, 32'h01);
		xfer(1'b1, 8'h10, 32'h1);
		xfer(1'b1, 8'h00, 32'h6);
		wait_out(1'b0, 400);
		chk("ew time", n >= 120 && n <= 200, 32'h1);
		chk("wake", wake_req, 32'h1);
		rc("open", 8'h18, 32'h4);
		xfer(1'b1, 8'h1c, 32'ha5);
		rc("restart", 8'h18, 32'h2);
		xfer(1'b1, 8'h0c, 32'h1);
		rc("ien off", 8'h10, 32'h0);
		chk("irq", irq, 32'h0);
		xfer(1'b1, 8'h1c, 32'h5a);
		rc("bad key", 8'h18, 32'h2);
		xfer(1'b1, 8'h1c, 32'ha5);
		wait_out(1'b1, 10);
		rc("early", 8'h18, 32'h1);
		rc("flag", 8'h14, 32'h1);
		xfer(1'b1, 8'h14, 32'h1);
		rc("flag clr", 8'h14, 32'h0);
		chk("ev count", n_ev, 32'h1);
	endtask
	task automatic t_timeout;
		do_reset();
		xfer(1'b1, 8'h04, 32'h01);
		xfer(1'b1, 8'h00, 32'h6);
		wait_out(1'b1, 700);
		chk("bite time", n >= 440 && n <= 540, 32'h1);
		chk("ev count 2", n_ev, 32'h2);
	endtask
	task automatic t_persist;
		do_reset();
		xfer(1'b1, 8'h00, 32'h80);
		xfer(1'b1, 8'h00, 32'h0);
		rc("persist", 8'h00, 32'h80);
		rc("running", 8'h18, 32'h4);
		xfer(1'b1, 8'h04, 32'h11);
		rc("cfg lock", 8'h04, 32'hbb);
		xfer(1'b1, 8'h08, 32'h3);
		rc("warn lock", 8'h08, 32'hb);
		xfer(1'b1, 8'h00, 32'h4);
		rc("window", 8'h00, 32'h84);
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		bus_clk_on = 1'b1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_window();
		t_timeout();
		t_persist();
		stop_test();
	end
endmodule
bind wwdg_top wwdg_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .wake_req(wake_req),
	.ew_event(ew_event), .sys_reset_req(sys_reset_req));

/* verif/wwdg_chk.sv */
// port checks for the windowed watchdog top
// assumes a bind from the bench top file
`timescale 1ns/100ps
module wwdg_chk (
	input wire logic        pclk,          // clock
	input wire logic        presetn,       // reset
	input wire logic        psel,          // select
	input wire logic        penable,       // enable
	input wire logic        pwrite,        // write
	input wire logic [7:0]  paddr,         // address
	input wire logic [31:0] pwdata,        // wdata
	input wire logic        pready,        // ready
	input wire logic        pslverr,       // error
	input wire logic        irq,           // irq
	input wire logic        wake_req,      // wake
	input wire logic        ew_event,      // event
	input wire logic        sys_reset_req  // bite
);
	// ****
	// helpers and properties
	// ****
	logic ien_seen;
	wire  wr_done = psel & penable & pready & pwrite;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) ien_seen <= 1'b0;
		else if (wr_done && paddr == 8'h10 && pwdata[0]) ien_seen <= 1'b1;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_wait; psel && penable && !pready |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("ready late");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready too long");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_ien; !ien_seen |-> !irq; endproperty
	a_ien: assert property (p_ien) else $error("irq before enable");
	property p_key; wr_done && paddr == 8'h1c && pwdata[7:0] != 8'ha5 && !sys_reset_req
		|=> !sys_reset_req; endproperty
	a_key: assert property (p_key) else $error("wrong key bit");
	property p_stick; sys_reset_req |=> sys_reset_req; endproperty
	a_stick: assert property (p_stick) else $error("bite dropped");
	property p_wake; wake_req == irq; endproperty
	a_wake: assert property (p_wake) else $error("wake differs");
	property p_ew; ew_event |=> !ew_event; endproperty
	a_ew: assert property (p_ew) else $error("event too long");
endmodule
